// File: snvo_pkg.sv
// constants and types of the sensor nibble video output block
package snvo_pkg;
	// ****************************************************
	// register map
	// ****************************************************
	localparam logic [7:0] SNVO_OUTPUT_CONTROL_ADDR = 8'h17; // output_control
	localparam logic [7:0] SNVO_OUTPUT_CONTROL_RST = 8'h00; // reset value
	localparam int SNVO_TRISTATE_BIT = 5; // output disable bit
	// ****************************************************
	// word values (10-bit form, control codes low 2 bits zero)
	// ****************************************************
	localparam logic [9:0] SNVO_ESC_WORD = 10'h3FC; // escape max word
	localparam logic [9:0] SNVO_ZERO_WORD = 10'h000; // escape zero word
	localparam logic [9:0] SNVO_CODE_SOF = 10'h31C; // start of frame
	localparam logic [9:0] SNVO_CODE_VIS = 10'h2D8; // visible line
	localparam logic [9:0] SNVO_CODE_LAST = 10'h368; // last line
	localparam logic [9:0] SNVO_CODE_EOL = 10'h200; // end of line
	// ****************************************************
	// pixel range and black level
	// ****************************************************
	localparam logic [10:0] SNVO_MIN10 = 11'h001; // 10-bit lowest value
	localparam logic [10:0] SNVO_MAX10 = 11'h3FE; // 10-bit highest, 1022
	localparam logic [10:0] SNVO_BLACK10 = 11'h040; // 10-bit black, 64
	localparam logic [8:0] SNVO_MIN8 = 9'h001; // 8-bit lowest value
	localparam logic [8:0] SNVO_MAX8 = 9'h0FE; // 8-bit highest, 254
	localparam logic [8:0] SNVO_BLACK8 = 9'h010; // 8-bit black, 16
	// ****************************************************
	// array and line layout
	// ****************************************************
	localparam logic [9:0] SNVO_LAST_COL = 10'h28F; // 656 columns
	localparam logic [8:0] SNVO_LAST_ROW = 9'h1EF; // 496 rows
	localparam logic [9:0] SNVO_SAV_LAST = 10'h005; // esc,esc,0,code,2 num
	localparam logic [9:0] SNVO_EAV_LAST = 10'h003; // esc,esc,0,eol
	localparam logic [9:0] SNVO_PAD_LAST = 10'h00F; // 16 idle words
	localparam logic [9:0] SNVO_IDX_ESC2 = 10'h001; // second escape word
	localparam logic [9:0] SNVO_IDX_ZERO = 10'h002; // zero word
	localparam logic [9:0] SNVO_IDX_CODE = 10'h003; // line code word
	localparam logic [9:0] SNVO_IDX_NUMH = 10'h004; // line number high
	// ****************************************************
	// types
	// ****************************************************
	typedef enum logic [3:0] {
		SNVO_ST_SAV = 4'b0001,
		SNVO_ST_PIX = 4'b0010,
		SNVO_ST_EAV = 4'b0100,
		SNVO_ST_PAD = 4'b1000
	} snvo_phase_type;
	// output pins, each enable low while driving
	typedef struct packed {
		logic [4:0] data;
		logic data_oe_n;
		logic qual_clock_pin;
		logic qual_clock_pin_oe_n;
		logic fst;
		logic fst_oe_n;
	} snvo_pins_type;
	// whole state of the formatter
	typedef struct packed {
		logic lck_s1;
		logic lck_s2;
		logic lck_d;
		logic sus_s1;
		logic sus_s2;
		logic [7:0] ctrl;
		logic [7:0] rdata;
		logic lower;
		snvo_phase_type st;
		logic [9:0] widx;
		logic [8:0] line;
		logic [9:0] word;
		logic take;
		logic por_n;
		snvo_pins_type pins;
	} snvo_state_type;
endpackage

// File: snvo_top.sv
// sensor nibble video output: line framing, nibble bus, qual_clock_pin and fst
`timescale 1ns/1ps
`default_nettype none
module snvo_top (
	input wire logic sys_clk_i, // system clock
	input wire logic rst_n_i, // synchronous reset, low active
	input wire logic sensor_clock_in_i, // sensor clock pin, async
	input wire logic suspend_i, // suspend pin, async, high active
	input wire logic wire4_mode_i, // static: 1 = 4-wire 8-bit mode
	input wire logic qual_clock_pin_fast_i, // static: 1 = fast qual_clock_pin
	input wire logic qual_clock_pin_en_i, // 1 = qual_clock_pin running, may change while the stream runs
	input wire logic [9:0] pix_data_i, // dark corrected pixel
	input wire logic cfg_wr_i, // serial interface write strobe
	input wire logic [7:0] cfg_addr_i, // serial interface address
	input wire logic [7:0] cfg_wdata_i, // serial interface write data
	output logic [7:0] cfg_rdata_o, // registered read data
	output logic pix_take_o, // pixel was consumed
	output logic power_on_reset_n_out_o, // reset for outside parts
	output snvo_pkg::snvo_pins_type pins_o // video pins
);
	import snvo_pkg::*;

	// ****************************************************
	// state
	// ****************************************************
	snvo_state_type s_r; // registered state
	snvo_state_type s_nxt; // next state
	logic lck_rise; // sensor clock rising edge seen
	logic lck_fall; // sensor clock falling edge seen
	logic [9:0] pix_word; // clamped pixel, 10-bit form
	logic [9:0] word_new; // word chosen for this pixel slot
	logic [9:0] line_code; // code for current line
	logic [4:0] nib_up; // upper nibble of word
	logic [4:0] nib_lo; // lower nibble of latched word

	// clamp a pixel with black pedestal; 8-bit sits in bits 9:2
	function automatic logic [9:0] clamp_pix(input logic [9:0] p,
		input logic w4);
		logic [10:0] s10;
		logic [8:0] s8;
		logic [9:0] r;
		s10 = {1'b0, p} + SNVO_BLACK10;
		s8 = {1'b0, p[9:2]} + SNVO_BLACK8;
		r = 10'h000;
		if (w4) begin
			// limits keep FF out, so escape cannot occur
			if (s8 > SNVO_MAX8) begin
				s8 = SNVO_MAX8;
			end else if (s8 < SNVO_MIN8) begin
				s8 = SNVO_MIN8;
			end
			r = {s8[7:0], 2'b00};
		end else begin
			if (s10 > SNVO_MAX10) begin
				s10 = SNVO_MAX10;
			end else if (s10 < SNVO_MIN10) begin
				s10 = SNVO_MIN10;
			end
			r = s10[9:0];
		end
		return r;
	endfunction

	// ****************************************************
	// word selection
	// ****************************************************
	// edges come from the second and third sync stages only
	always_comb begin
		lck_rise = s_r.lck_s2 & ~s_r.lck_d;
		lck_fall = ~s_r.lck_s2 & s_r.lck_d;
		pix_word = clamp_pix(pix_data_i, wire4_mode_i);
		// line type code from the row counter
		if (s_r.line == 9'h000) begin
			line_code = SNVO_CODE_SOF;
		end else if (s_r.line == SNVO_LAST_ROW) begin
			line_code = SNVO_CODE_LAST;
		end else begin
			line_code = SNVO_CODE_VIS;
		end
		word_new = SNVO_ZERO_WORD;
		unique case (s_r.st)
			SNVO_ST_SAV: begin
				// escape then code and line number
				if (s_r.widx < SNVO_IDX_ZERO) begin
					word_new = SNVO_ESC_WORD;
				end else if (s_r.widx == SNVO_IDX_CODE) begin
					word_new = line_code;
				end else if (s_r.widx == SNVO_IDX_NUMH) begin
					word_new = {7'h00, s_r.line[8], 2'b00};
				end else if (s_r.widx > SNVO_IDX_NUMH) begin
					word_new = {s_r.line[7:0], 2'b00};
				end
			end
			SNVO_ST_PIX: begin
				word_new = pix_word; // pixel data
			end
			SNVO_ST_EAV: begin
				// escape then end-of-line code
				if (s_r.widx <= SNVO_IDX_ESC2) begin
					word_new = SNVO_ESC_WORD;
				end else if (s_r.widx == SNVO_IDX_CODE) begin
					word_new = SNVO_CODE_EOL;
				end
			end
			SNVO_ST_PAD: begin
				word_new = SNVO_ZERO_WORD; // interline idle
			end
		endcase
		// nibble split per static bus width
		if (wire4_mode_i) begin
			nib_up = {1'b0, word_new[9:6]};
			nib_lo = {1'b0, s_r.word[5:2]};
		end else begin
			nib_up = word_new[9:5];
			nib_lo = s_r.word[4:0];
		end
	end

	// ****************************************************
	// next state
	// ****************************************************
	always_comb begin
		s_nxt = s_r;
		s_nxt.take = 1'b0;
		s_nxt.por_n = 1'b1; // released after reset
		// two-stage synchronisers for pins
		s_nxt.lck_s1 = sensor_clock_in_i;
		s_nxt.lck_s2 = s_r.lck_s1;
		s_nxt.lck_d = s_r.lck_s2;
		s_nxt.sus_s1 = suspend_i;
		s_nxt.sus_s2 = s_r.sus_s1;
		// register write and read from the serial interface
		if (cfg_wr_i && cfg_addr_i == SNVO_OUTPUT_CONTROL_ADDR) begin
			s_nxt.ctrl = cfg_wdata_i;
		end
		if (cfg_addr_i == SNVO_OUTPUT_CONTROL_ADDR) begin
			s_nxt.rdata = s_r.ctrl;
		end else begin
			s_nxt.rdata = 8'h00;
		end
		if (s_r.sus_s2) begin
			// suspended: park at frame start
			s_nxt.st = SNVO_ST_SAV;
			s_nxt.widx = 10'h000;
			s_nxt.line = 9'h000;
			s_nxt.lower = 1'b0;
		end else if (lck_rise) begin
			if (!s_r.lower) begin
				// present upper nibble, latch word, step slot
				s_nxt.pins.data = nib_up;
				s_nxt.word = word_new;
				s_nxt.lower = 1'b1;
				s_nxt.widx = s_r.widx + 10'h001;
				unique case (s_r.st)
					SNVO_ST_SAV: begin
						if (s_r.widx == SNVO_SAV_LAST) begin
							s_nxt.st = SNVO_ST_PIX;
							s_nxt.widx = 10'h000;
						end
					end
					SNVO_ST_PIX: begin
						s_nxt.take = 1'b1;
						// 656 columns per row
						if (s_r.widx == SNVO_LAST_COL) begin
							s_nxt.st = SNVO_ST_EAV;
							s_nxt.widx = 10'h000;
						end
					end
					SNVO_ST_EAV: begin
						if (s_r.widx == SNVO_EAV_LAST) begin
							s_nxt.st = SNVO_ST_PAD;
							s_nxt.widx = 10'h000;
						end
					end
					SNVO_ST_PAD: begin
						if (s_r.widx == SNVO_PAD_LAST) begin
							s_nxt.st = SNVO_ST_SAV;
							s_nxt.widx = 10'h000;
							// 496 rows per frame
							if (s_r.line == SNVO_LAST_ROW) begin
								s_nxt.line = 9'h000;
							end else begin
								s_nxt.line = s_r.line + 9'h001;
							end
						end
					end
				endcase
			end else begin
				// present lower nibble of latched word
				s_nxt.pins.data = nib_lo;
				s_nxt.lower = 1'b0;
			end
		end
		// qualification clock, free running while enabled, except in slow mode during suspend
		if (!qual_clock_pin_en_i) begin
			s_nxt.pins.qual_clock_pin = 1'b0;
		end else if (qual_clock_pin_fast_i) begin
			// rise with each nibble, fall mid nibble
			if (lck_rise) begin
				s_nxt.pins.qual_clock_pin = 1'b1;
			end else if (lck_fall) begin
				s_nxt.pins.qual_clock_pin = 1'b0;
			end
		end else if (lck_fall) begin
			// high mid upper, low mid lower
			s_nxt.pins.qual_clock_pin = s_r.lower;
		end
		// frame start high over first line
		s_nxt.pins.fst = (s_nxt.line == 9'h000) && !s_r.sus_s2;
		// output disable floats all video pins
		s_nxt.pins.data_oe_n = s_r.ctrl[SNVO_TRISTATE_BIT];
		s_nxt.pins.qual_clock_pin_oe_n = s_r.ctrl[SNVO_TRISTATE_BIT];
		s_nxt.pins.fst_oe_n = s_r.ctrl[SNVO_TRISTATE_BIT];
	end

	// ****************************************************
	// state register
	// ****************************************************
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			s_r <= '0;
			s_r.ctrl <= SNVO_OUTPUT_CONTROL_RST;
			s_r.st <= SNVO_ST_SAV;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ****************************************************
	// outputs, straight from flops
	// ****************************************************
	assign cfg_rdata_o = s_r.rdata;
	assign pix_take_o = s_r.take;
	assign power_on_reset_n_out_o = s_r.por_n;
	assign pins_o = s_r.pins;
endmodule
`default_nettype wire

// File: snvo_top_asserts.sv
// port assertions of the nibble video output
`timescale 1ns/1ps
`default_nettype none
module snvo_top_asserts (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic sensor_clock_in_i,
	input wire logic suspend_i,
	input wire logic wire4_mode_i,
	input wire logic qual_clock_pin_fast_i,
	input wire logic qual_clock_pin_en_i,
	input wire logic [9:0] pix_data_i,
	input wire logic cfg_wr_i,
	input wire logic [7:0] cfg_addr_i,
	input wire logic [7:0] cfg_wdata_i,
	input wire logic [7:0] cfg_rdata_o,
	input wire logic pix_take_o,
	input wire logic power_on_reset_n_out_o,
	input wire snvo_pkg::snvo_pins_type pins_o
);
	import snvo_pkg::*;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	logic [4:0] still_r; // cycles since qual_clock_pin last moved
	// counts a qual_clock_pin that has stopped moving
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i || !qual_clock_pin_en_i || $changed(pins_o.qual_clock_pin)) begin
			still_r <= 5'h00;
		end else begin
			still_r <= still_r + 5'h01;
		end
	end
	sequence s_ctrl_write;
		cfg_wr_i && cfg_addr_i == SNVO_OUTPUT_CONTROL_ADDR;
	endsequence
	sequence s_ctrl_read;
		s_ctrl_write ##1 (!cfg_wr_i && cfg_addr_i == SNVO_OUTPUT_CONTROL_ADDR);
	endsequence
	a_tristate_follow: assert property (s_ctrl_write |=> ##1
		pins_o.data_oe_n == $past(cfg_wdata_i[SNVO_TRISTATE_BIT], 2)
		&& pins_o.qual_clock_pin_oe_n == pins_o.data_oe_n
		&& pins_o.fst_oe_n == pins_o.data_oe_n)
		else $error("disable bit not on pins");
	a_ctrl_readback: assert property (s_ctrl_read |=>
		cfg_rdata_o == $past(cfg_wdata_i, 2)) else $error("bad readback");
	a_unmapped_zero: assert property (
		cfg_addr_i != SNVO_OUTPUT_CONTROL_ADDR |=> cfg_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	a_qual_clock_pin_held: assert property (!qual_clock_pin_en_i && !$past(qual_clock_pin_en_i)
		|-> !pins_o.qual_clock_pin) else $error("disabled qual_clock_pin moved");
	a_qual_clock_pin_runs: assert property (qual_clock_pin_en_i |-> still_r < 5'h10)
		else $error("qual_clock_pin stopped");
	a_fast_mark: assert property (qual_clock_pin_fast_i && $past(qual_clock_pin_fast_i)
		&& qual_clock_pin_en_i && $past(qual_clock_pin_en_i)
		&& $changed(pins_o.data) |-> $rose(pins_o.qual_clock_pin))
		else $error("nibble without qual_clock_pin rise");
	a_slow_apart: assert property (!qual_clock_pin_fast_i && !$past(qual_clock_pin_fast_i)
		&& qual_clock_pin_en_i && $past(qual_clock_pin_en_i)
		&& $changed(pins_o.data) |-> $stable(pins_o.qual_clock_pin))
		else $error("slow qual_clock_pin moved with nibble");
	a_nibble_holds: assert property ($changed(pins_o.data) |=>
		$stable(pins_o.data)[*4]) else $error("nibble too short");
	a_take_single: assert property (pix_take_o |=> (!pix_take_o)[*8])
		else $error("pixel taken too often");
	a_por_high: assert property ($past(rst_n_i) |->
		power_on_reset_n_out_o) else $error("reset out low");
	a_fst_start: assert property ($rose(rst_n_i) |=> pins_o.fst)
		else $error("no frame start after reset");
endmodule
bind snvo_top snvo_top_asserts u_asserts (.sys_clk_i, .rst_n_i,
	.sensor_clock_in_i, .suspend_i, .wire4_mode_i, .qual_clock_pin_fast_i,
	.qual_clock_pin_en_i, .pix_data_i, .cfg_wr_i, .cfg_addr_i, .cfg_wdata_i,
	.cfg_rdata_o, .pix_take_o, .power_on_reset_n_out_o, .pins_o);
`default_nettype wire

// File: snvo_cap_model.sv
// capturing co-processor: makes the sensor clock, rebuilds words
`timescale 1ns/1ps
`default_nettype none
module snvo_cap_model (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire snvo_pkg::snvo_pins_type pins_i,
	input wire logic slow_i, // qual_clock_pin runs in slow mode
	output logic sensor_clock_o,
	output logic [9:0] word_o,
	output logic word_stb_o
);
	import snvo_pkg::*;
	logic qual_clock_pin_d; // qual_clock_pin one cycle ago
	logic half; // lower nibble expected next
	logic [4:0] upper; // held upper nibble
	// sensor clock free running, 80 ns period
	initial begin
		sensor_clock_o = 1'b0;
		forever #40 sensor_clock_o = ~sensor_clock_o;
	end
	// fast: each qual_clock_pin fall qualifies one nibble, upper first
	always_ff @(posedge sys_clk_i) begin
		word_stb_o <= 1'b0;
		qual_clock_pin_d <= pins_i.qual_clock_pin;
		if (!rst_n_i) begin
			half <= 1'b0;
			word_o <= 10'h000;
		end else if (slow_i) begin
			// slow: rise marks upper, fall marks lower
			if (!qual_clock_pin_d && pins_i.qual_clock_pin) begin
				upper <= pins_i.data;
			end else if (qual_clock_pin_d && !pins_i.qual_clock_pin) begin
				word_o <= {upper, pins_i.data};
				word_stb_o <= 1'b1;
			end
		end else if (qual_clock_pin_d && !pins_i.qual_clock_pin) begin
			half <= ~half;
			if (!half) begin
				upper <= pins_i.data;
			end else begin
				word_o <= {upper, pins_i.data};
				word_stb_o <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// File: snvo_top_tb.sv
// self-checking bench of the nibble video output
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
	err_total++; $display("wrong value at %0t: %h not %h", $time, \
	a, b); end end
module snvo_top_tb;
	import snvo_pkg::*;
	typedef struct packed {
		logic w4;
		logic [9:0] pix;
		logic [9:0] exp10;
	} snvo_row_type;
	logic clk, rst_n, w4, fast, en, wr, take, por, stb, sclk, sus;
	logic [4:0] held;
	logic [9:0] pix, word;
	logic [7:0] addr, wdata, rdata;
	snvo_pins_type pins;
	int err_total, comparisons, nw, lp;
	snvo_row_type rows [6] = '{'{1'b0, 10'h000, 10'h040},
		'{1'b0, 10'h064, 10'h0A4}, '{1'b0, 10'h3BE, 10'h3FE},
		'{1'b0, 10'h3FF, 10'h3FE}, '{1'b1, 10'h3FF, 10'h3F8},
		'{1'b1, 10'h000, 10'h040}};
	logic [9:0] hdr [6] = '{SNVO_ESC_WORD, SNVO_ESC_WORD, SNVO_ZERO_WORD,
		SNVO_CODE_SOF, 10'h000, 10'h000};
	logic [9:0] eav [4] = '{SNVO_ESC_WORD, SNVO_ESC_WORD, SNVO_ZERO_WORD,
		SNVO_CODE_EOL};
	// header of the second line, line number one
	logic [9:0] hdr1 [6] = '{SNVO_ESC_WORD, SNVO_ESC_WORD, SNVO_ZERO_WORD,
		SNVO_CODE_VIS, 10'h000, 10'h004};
	snvo_top dut (.sys_clk_i(clk), .rst_n_i(rst_n),
		.sensor_clock_in_i(sclk), .suspend_i(sus),
		.wire4_mode_i(w4), .qual_clock_pin_fast_i(fast), .qual_clock_pin_en_i(en),
		.pix_data_i(pix), .cfg_wr_i(wr), .cfg_addr_i(addr),
		.cfg_wdata_i(wdata), .cfg_rdata_o(rdata), .pix_take_o(take),
		.power_on_reset_n_out_o(por), .pins_o(pins));
	snvo_cap_model u_cap (.sys_clk_i(clk), .rst_n_i(rst_n), .pins_i(pins),
		.slow_i(!fast), .sensor_clock_o(sclk), .word_o(word),
		.word_stb_o(stb));
	// word as rebuilt from two 4-wire nibbles
	function automatic logic [9:0] on_wire(input logic m,
		input logic [9:0] x);
		return m ? {1'b0, x[9:6], 1'b0, x[5:2]} : x;
	endfunction
	task automatic close_out();
		$display("comparisons %0d, mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// bounded wait for a one-cycle pulse
	task automatic wait_hi(ref logic s);
		int i;
		for (i = 0; i < 400; i++) begin
			@(negedge clk);
			if (s) break;
		end
		if (i == 400) begin
			err_total++;
			close_out();
		end
	endtask
	task automatic next_word();
		wait_hi(stb);
		nw++;
	endtask
	// mode is changed only under reset
	task automatic restart(input logic m, input logic f);
		int i;
		@(negedge clk);
		rst_n = 1'b0;
		w4 = m;
		fast = f;
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		nw = 0;
		repeat (2) @(negedge clk);
		`CHK(por, 1'b1)
		`CHK(pins.fst, 1'b1)
		for (i = 0; i < 6; i++) begin
			next_word();
			`CHK(word, on_wire(m, hdr[i]))
		end
		$display("reset and line header done, mode %0d", m);
	endtask
	// register write over the serial interface
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		wr = 1'b1;
		addr = a;
		wdata = d;
		@(negedge clk);
		wr = 1'b0;
		repeat (2) @(negedge clk);
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		rst_n = 1'b0;
		w4 = 1'b1;
		fast = 1'b1;
		en = 1'b1;
		sus = 1'b0;
		wr = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		pix = 10'h000;
		err_total = 0;
		comparisons = 0;
		nw = 0;
		foreach (rows[k]) begin
			if (rows[k].w4 != w4) restart(rows[k].w4, 1'b1);
			pix = rows[k].pix;
			wait_hi(take);
			next_word();
			`CHK(word, on_wire(w4, rows[k].exp10))
		end
		$display("pixel rows done");
		while (nw < 662) next_word();
		foreach (eav[i]) begin
			next_word();
			`CHK(word, on_wire(w4, eav[i]))
		end
		$display("line end done");
		// interline idle, then the next line's header
		repeat (16) begin
			next_word();
			`CHK(word, SNVO_ZERO_WORD)
		end
		foreach (hdr1[i]) begin
			next_word();
			`CHK(word, on_wire(w4, hdr1[i]))
		end
		`CHK(pins.fst, 1'b0)
		$display("second line header done");
		put(SNVO_OUTPUT_CONTROL_ADDR, 8'h20);
		`CHK({pins.data_oe_n, pins.qual_clock_pin_oe_n, pins.fst_oe_n}, 3'h7)
		`CHK(rdata, 8'h20)
		put(8'h18, 8'h00);
		`CHK(rdata, 8'h00)
		`CHK(pins.data_oe_n, 1'b1)
		put(SNVO_OUTPUT_CONTROL_ADDR, 8'h00);
		`CHK(pins.qual_clock_pin_oe_n, 1'b0)
		$display("output disable done");
		en = 1'b0;
		repeat (4) @(negedge clk);
		repeat (8) begin
			@(negedge clk);
			`CHK(pins.qual_clock_pin, 1'b0)
		end
		en = 1'b1;
		repeat (40) @(negedge clk);
		$display("qual_clock_pin enable done");
		// suspend parks the stream, resume restarts the frame
		sus = 1'b1;
		repeat (4) @(negedge clk);
		held = pins.data;
		repeat (20) @(negedge clk);
		`CHK(pins.fst, 1'b0)
		`CHK(pins.data, held)
		sus = 1'b0;
		repeat (4) @(negedge clk);
		`CHK(pins.fst, 1'b1)
		for (lp = 0; lp < 40 && pins.data == held; lp++) @(negedge clk);
		`CHK(pins.data, ({1'b0, SNVO_ESC_WORD[9:6]}))
		$display("suspend done");
		// slow qual_clock_pin: header rebuilt from rise and fall marks
		restart(1'b1, 1'b0);
		close_out();
	end
endmodule
`default_nettype wire
